// ==== src/tsa_fifo.sv ====
`timescale 1ns/1ps
module tsa_fifo
  #(parameter int WIDTH = 1,
    parameter int DEPTH = 16)
   (input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;
   wire              push;
   wire              pop;

   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;
   assign outValid = wrPtr != rdPtr;
   assign inReady  = (wrPtr[AW] == rdPtr[AW]) | (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
   assign outData  = mem[rdPtr[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         wrPtr <= wrPtr + (AW+1)'(push);
         rdPtr <= rdPtr + (AW+1)'(pop);
      end
   end

endmodule : tsa_fifo

// ==== src/tsa_pkg.sv ====
package tsa_pkg;

   // Counter and bus geometry
   localparam int TSA_CNT_W      = 8;
   localparam int TSA_ADR_W      = 5;
   localparam int TSA_DAT_W      = 32;
   localparam int TSA_SEL_W      = 4;
   localparam int TSA_FIFO_DEPTH = 16;
   localparam int TSA_FIFO_W     = 1;

   // Register byte offsets
   localparam logic [TSA_ADR_W-1:0] TSA_OFS_CTRL    = 5'h00;
   localparam logic [TSA_ADR_W-1:0] TSA_OFS_PRELOAD = 5'h04;
   localparam logic [TSA_ADR_W-1:0] TSA_OFS_COUNT   = 5'h08;
   localparam logic [TSA_ADR_W-1:0] TSA_OFS_STATUS  = 5'h0C;
   localparam logic [TSA_ADR_W-1:0] TSA_OFS_TXBIT   = 5'h10;
   localparam logic [TSA_ADR_W-1:0] TSA_OFS_RXBIT   = 5'h14;

   // Control field positions
   localparam int TSA_CTRL_SEL_LO = 0;
   localparam int TSA_CTRL_SEL_HI = 1;
   localparam int TSA_CTRL_RUN    = 2;
   localparam int TSA_CTRL_START  = 3;
   localparam int TSA_CTRL_TXEN   = 4;

   // Status field positions
   localparam int TSA_STAT_RX     = 0;
   localparam int TSA_STAT_RXNEW  = 1;
   localparam int TSA_STAT_TX     = 2;
   localparam int TSA_STAT_FULL   = 3;
   localparam int TSA_STAT_EMPTY  = 4;
   localparam int TSA_STAT_ST_LO  = 5;
   localparam int TSA_STAT_ST_HI  = 6;

   // Reset and constant values
   localparam logic [TSA_CNT_W-1:0] TSA_CTRL_RST    = 8'h00;
   localparam logic [TSA_CNT_W-1:0] TSA_PRELOAD_RST = 8'h00;
   localparam logic [TSA_CNT_W-1:0] TSA_COUNT_RST   = 8'h00;
   localparam logic [TSA_CNT_W-1:0] TSA_CNT_MAX     = 8'hFF;
   localparam logic [TSA_CNT_W-1:0] TSA_CNT_ONE     = 8'h01;
   localparam logic                 TSA_LINE_IDLE   = 1'b1;
   localparam logic [TSA_DAT_W-1:0] TSA_DAT_ZERO    = 32'h0000_0000;

   typedef enum logic [1:0] {
      TSA_CLK_MCLK = 2'h0,
      TSA_CLK_ACLK = 2'h1,
      TSA_CLK_EXT  = 2'h2,
      TSA_CLK_AND  = 2'h3
   } tsa_clksel_t;

   typedef enum logic [1:0] {
      TSA_ST_STOP = 2'h0,
      TSA_ST_WAIT = 2'h1,
      TSA_ST_RUN  = 2'h3
   } tsa_state_t;

endpackage : tsa_pkg

// ==== src/tsa_sync.sv ====
`timescale 1ns/1ps
module tsa_sync
  #(parameter int WIDTH = 2)
   (input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced);

   logic [WIDTH-1:0] stage1;

   // Two-flop synchroniser, first stage feeds only the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '1;
         synced <= '1;
      end else begin
         stage1 <= async;
         synced <= stage1;
      end
   end

endmodule : tsa_sync

// ==== src/tsa_timer.sv ====
// Operation
// RULE1: Eight-bit counter with preload and control registers
// RULE2: Two bits pick one of four clocks
// RULE3: Counter write loads preload into counter
// RULE4: Preload rewritable without disturbing running count
// RULE5: Count up per clock while enabled
// RULE6: Start-detect mode waits for start edge
// RULE7: First sample after first full interval
// RULE8: Carry-out clocks receive and transmit latches
// RULE9: Hardware shifts one bit per interval
// RULE10: Shared pins give input and serial output
// RULE11: Carry-out reloads counter from preload
`timescale 1ns/1ps
module tsa_timer
  #(parameter int FIFO_DEPTH = tsa_pkg::TSA_FIFO_DEPTH)
   (input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic                          wbCyc,
    input  wire logic                          wbStb,
    input  wire logic                          wbWe,
    input  wire logic [tsa_pkg::TSA_ADR_W-1:0] wbAdr,
    input  wire logic [tsa_pkg::TSA_SEL_W-1:0] wbSel,
    input  wire logic [tsa_pkg::TSA_DAT_W-1:0] wbDatW,
    output logic      [tsa_pkg::TSA_DAT_W-1:0] wbDatR,
    output logic                               wbAck,
    input  wire logic                          auxClock,
    input  wire logic                          sharedExternalInput,
    output logic                               serialOut,
    output logic                               serialOutEn);

   import tsa_pkg::*;

   // Synchronised pins
   logic [1:0]           syncBits;
   logic                 auxPrev;
   logic                 extPrev;
   wire                  auxLevel;
   wire                  extLevel;
   wire                  auxRise;
   wire                  extRise;
   wire                  extFall;

   // Registers and state
   logic [TSA_CNT_W-1:0] ctrl;
   logic [TSA_CNT_W-1:0] preload;
   logic [TSA_CNT_W-1:0] count;
   logic                 receiveSampleLatch;
   logic                 rxNew;
   tsa_state_t           state;
   tsa_state_t           next_state;
   logic [TSA_CNT_W-1:0] next_count;

   // Bus decode
   wire                  busReq;
   wire                  hitCtrl;
   wire                  hitPre;
   wire                  hitCount;
   wire                  hitStat;
   wire                  hitTx;
   wire                  hitRx;
   wire                  txStall;
   wire                  accept;
   wire                  wrLane;
   wire                  wrCtrl;
   wire                  wrPre;
   wire                  loadCnt;
   wire                  rdRx;
   wire [TSA_DAT_W-1:0]  next_rdData;
   wire [TSA_CNT_W-1:0]  statusWord;

   // Counter control
   tsa_clksel_t          clkSel;
   wire                  running;
   wire                  tick;
   wire                  step;
   wire                  wrap;

   // Transmit bit buffer
   wire                  fifoInValid;
   wire                  fifoInReady;
   wire                  fifoOutValid;
   wire [TSA_FIFO_W-1:0] fifoOutData;

   tsa_sync #(.WIDTH(2)) uSync (
      .clk    (clk),
      .rst_b  (rst_b),
      .async  ({sharedExternalInput, auxClock}),
      .synced (syncBits));

   assign auxLevel = syncBits[0];
   assign extLevel = syncBits[1];

   // Edge detect on the shared input and the auxiliary clock
   assign auxRise = auxLevel & ~auxPrev;
   assign extRise = extLevel & ~extPrev;               // [RULE10]
   assign extFall = ~extLevel & extPrev;               // [RULE10]

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         auxPrev <= TSA_LINE_IDLE;
         extPrev <= TSA_LINE_IDLE;
      end else begin
         auxPrev <= auxLevel;
         extPrev <= extLevel;
      end
   end

   // Wishbone slave decode
   assign busReq   = wbCyc & wbStb & ~wbAck;
   assign wrLane   = wbSel[0];
   assign hitCtrl  = wbAdr == TSA_OFS_CTRL;
   assign hitPre   = wbAdr == TSA_OFS_PRELOAD;
   assign hitCount = wbAdr == TSA_OFS_COUNT;
   assign hitStat  = wbAdr == TSA_OFS_STATUS;
   assign hitTx    = wbAdr == TSA_OFS_TXBIT;
   assign hitRx    = wbAdr == TSA_OFS_RXBIT;
   assign txStall  = hitTx & wbWe & wrLane & ~fifoInReady;
   assign accept   = busReq & ~txStall;
   assign wrCtrl   = accept & wbWe & hitCtrl & wrLane;
   assign wrPre    = accept & wbWe & hitPre & wrLane;
   assign loadCnt  = accept & wbWe & hitCount;          // [RULE3]
   assign rdRx     = accept & ~wbWe & hitRx;

   assign statusWord = {1'b0,
                        state,
                        ~fifoOutValid,
                        ~fifoInReady,
                        serialOut,
                        rxNew,
                        receiveSampleLatch};

   assign next_rdData =
      wbWe     ? TSA_DAT_ZERO :
      hitCtrl  ? {24'h00_0000, ctrl} :
      hitPre   ? {24'h00_0000, preload} :
      hitCount ? {24'h00_0000, count} :
      hitStat  ? {24'h00_0000, statusWord} :
      hitRx    ? {31'h0000_0000, receiveSampleLatch} :
                 TSA_DAT_ZERO;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wbAck  <= 1'b0;
         wbDatR <= TSA_DAT_ZERO;
      end else begin
         wbAck  <= accept;
         wbDatR <= accept ? next_rdData : TSA_DAT_ZERO;
      end
   end

   // Control and preload registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl    <= TSA_CTRL_RST;
         preload <= TSA_PRELOAD_RST;
      end else begin
         if (wrCtrl) begin
            ctrl <= wbDatW[TSA_CNT_W-1:0];
         end
         if (wrPre) begin
            preload <= wbDatW[TSA_CNT_W-1:0];       // [RULE4]
         end
      end
   end

   // Clock source selection
   assign clkSel = tsa_clksel_t'(ctrl[TSA_CTRL_SEL_HI:TSA_CTRL_SEL_LO]);
   assign tick   = (clkSel == TSA_CLK_MCLK) ? 1'b1 :
                   (clkSel == TSA_CLK_ACLK) ? auxRise :
                   (clkSel == TSA_CLK_EXT)  ? extRise :
                                              extLevel;  // [RULE2]

   // Run, step and carry-out
   assign running = state == TSA_ST_RUN;
   assign step    = running & tick & ~loadCnt;          // [RULE5]
   assign wrap    = step & (count == TSA_CNT_MAX);

   // Start-bit wait state machine
   always_comb begin
      next_state = state;
      if (!ctrl[TSA_CTRL_RUN] | wrCtrl) begin
         next_state = TSA_ST_STOP;
      end else begin
         case (state)
            TSA_ST_STOP: begin
               next_state = ctrl[TSA_CTRL_START] ? TSA_ST_WAIT
                                                 : TSA_ST_RUN;
            end
            TSA_ST_WAIT: begin
               if (extFall) begin
                  next_state = TSA_ST_RUN;             // [RULE6]
               end
            end
            TSA_ST_RUN: begin
               next_state = TSA_ST_RUN;
            end
            default: begin
               next_state = TSA_ST_STOP;
            end
         endcase
      end
   end

   always_comb begin
      next_count = count;
      if (loadCnt) begin
         next_count = preload;                          // [RULE3]
      end else if (wrap) begin
         next_count = preload;                          // [RULE11]
      end else if (step) begin
         next_count = count + TSA_CNT_ONE;              // [RULE5]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= TSA_ST_STOP;
         count <= TSA_COUNT_RST;
      end else begin
         state <= next_state;
         count <= next_count;                           // [RULE1]
      end
   end

   // Receive sample latch and transmit output latch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         receiveSampleLatch <= TSA_LINE_IDLE;
         rxNew              <= 1'b0;
         serialOut          <= TSA_LINE_IDLE;
         serialOutEn        <= 1'b0;
      end else begin
         if (wrap) begin
            receiveSampleLatch <= extLevel;             // [RULE7] [RULE8]
         end
         if (wrap & fifoOutValid) begin
            serialOut <= fifoOutData[0];                // [RULE8] [RULE9]
         end
         rxNew       <= wrap | (rxNew & ~rdRx);
         serialOutEn <= ctrl[TSA_CTRL_TXEN];            // [RULE10]
      end
   end

   // Software-supplied bits wait here for the next interval
   assign fifoInValid = accept & wbWe & hitTx & wrLane;

   tsa_fifo #(.WIDTH(TSA_FIFO_W), .DEPTH(FIFO_DEPTH)) uTxFifo (
      .clk      (clk),
      .rst_b    (rst_b),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (wbDatW[TSA_FIFO_W-1:0]),
      .outValid (fifoOutValid),
      .outReady (wrap),                                 // [RULE9]
      .outData  (fifoOutData));

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_load_from_preload: assert property (        // [RULE3]
      loadCnt |=> count == $past(preload))
      else $error("counter write did not load preload");

   a_preload_no_disturb: assert property (       // [RULE4]
      wrPre && !loadCnt && !step |=> count == $past(count))
      else $error("preload write disturbed count");

   a_count_increment: assert property (          // [RULE5]
      step && !wrap |=> count == $past(count) + TSA_CNT_ONE)
      else $error("counter did not step by one");

   a_count_hold: assert property (               // [RULE5]
      !running && !loadCnt |=> $stable(count))
      else $error("counter moved while stopped");

   a_start_wait: assert property (               // [RULE6]
      state == TSA_ST_WAIT && !extFall && !wrCtrl && ctrl[TSA_CTRL_RUN]
      && !loadCnt |=> state == TSA_ST_WAIT && $stable(count))
      else $error("counter left start wait without edge");

   a_first_sample: assert property (             // [RULE7]
      wrap |=> receiveSampleLatch == $past(extLevel) && rxNew)
      else $error("receive latch missed interval sample");

   a_latch_hold: assert property (               // [RULE8]
      !wrap |=> $stable(receiveSampleLatch) && $stable(serialOut))
      else $error("data latch changed without carry-out");

   a_tx_shift: assert property (                 // [RULE9]
      wrap && fifoOutValid |=> serialOut == $past(fifoOutData[0]))
      else $error("transmit latch missed buffered bit");

   a_and_gate: assert property (                 // [RULE2]
      running && clkSel == TSA_CLK_AND && !extLevel && !loadCnt
      |=> $stable(count))
      else $error("gated clock counted with input low");

   a_out_enable: assert property (               // [RULE10]
      ctrl[TSA_CTRL_TXEN] ##1 ctrl[TSA_CTRL_TXEN] |-> serialOutEn)
      else $error("serial output not driven when enabled");

   a_carry_reload: assert property (             // [RULE11]
      wrap |=> count == $past(preload))
      else $error("carry-out did not reload counter");

   a_wait_to_run: assert property (              // [RULE6]
      state == TSA_ST_WAIT && extFall && !wrCtrl && ctrl[TSA_CTRL_RUN]
      |=> running)
      else $error("start edge did not start counter");

   a_clock_mclk: assert property (               // [RULE2]
      running && clkSel == TSA_CLK_MCLK && !loadCnt && count != TSA_CNT_MAX
      |=> count == $past(count) + TSA_CNT_ONE)
      else $error("master clock source did not count");

   a_aux_edge: assert property (                 // [RULE2]
      running && clkSel == TSA_CLK_ACLK && !auxRise && !loadCnt
      |=> $stable(count))
      else $error("auxiliary source counted without edge");

   a_ext_edge: assert property (                 // [RULE2]
      running && clkSel == TSA_CLK_EXT && !extRise && !loadCnt
      |=> $stable(count))
      else $error("external source counted without edge");

   a_rx_new_set: assert property (               // [RULE8]
      rdRx && wrap |=> rxNew)
      else $error("carry-out lost to receive read");

   a_rx_new_clear: assert property (             // [RULE8]
      rdRx && !wrap |=> !rxNew)
      else $error("receive read did not clear new flag");

   a_tx_hold_empty: assert property (            // [RULE9]
      wrap && !fifoOutValid |=> $stable(serialOut))
      else $error("transmit latch changed with buffer empty");

   a_out_mirror: assert property (               // [RULE10]
      serialOutEn == $past(ctrl[TSA_CTRL_TXEN]))
      else $error("serial output enable not following control");

   c_carry_out: cover property (wrap);
   c_start_seen: cover property (state == TSA_ST_WAIT ##1 running);
   c_tx_stall: cover property (busReq && txStall);
   c_rx_read: cover property (rdRx && rxNew);

endmodule : tsa_timer

// ==== tb/tb_tsa_timer.sv ====
`timescale 1ns/1ps
module tb_tsa_timer;
   import tsa_pkg::*;
   logic                 clk;
   logic                 rst_b;
   logic                 wbCyc;
   logic                 wbStb;
   logic                 wbWe;
   logic [TSA_ADR_W-1:0] wbAdr;
   logic [TSA_SEL_W-1:0] wbSel;
   logic [TSA_SEL_W-1:0] selUse;
   logic [TSA_DAT_W-1:0] wbDatW;
   logic [TSA_DAT_W-1:0] wbDatR;
   logic                 wbAck;
   logic                 auxClock;
   logic                 extLine;
   logic                 serialOut;
   logic                 serialOutEn;
   logic [TSA_DAT_W-1:0] rdq;
   int                   errCount;
   int                   checksDone;

   tsa_timer #(.FIFO_DEPTH(TSA_FIFO_DEPTH)) dut (
      .clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
      .wbDatR(wbDatR), .wbAck(wbAck), .auxClock(auxClock),
      .sharedExternalInput(extLine), .serialOut(serialOut),
      .serialOutEn(serialOutEn));

   tsa_serial_peer peer (.clk(clk), .line(extLine));

   always #5 clk = ~clk;

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask : check

   // Classic single cycle, held until ack is sampled
   task xfer(input logic we, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= d;
      wbSel <= selUse;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 200);
      rdq = wbDatR;
      if (n >= 200) check(32'h0000_0000, 32'h0000_0001);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk);
   endtask : xfer

   task wr(input logic [4:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task rdCheck(input logic [4:0] a, input logic [31:0] m,
                input logic [31:0] e);
      xfer(1'b0, a, TSA_DAT_ZERO);
      check(rdq & m, e);
   endtask : rdCheck

   task resetValues;
      check({31'h0, serialOut}, 32'h0000_0001);
      check({31'h0, serialOutEn}, 32'h0000_0000);
      rdCheck(TSA_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
      rdCheck(TSA_OFS_PRELOAD, 32'hFFFF_FFFF, 32'h0000_0000);
      rdCheck(TSA_OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_0000);
      rdCheck(TSA_OFS_STATUS, 32'hFFFF_FFFE, 32'h0000_0014);
      wr(TSA_OFS_STATUS, 32'h0000_00FF);
      rdCheck(TSA_OFS_STATUS, 32'hFFFF_FFFE, 32'h0000_0014);
      wr(5'h1C, 32'h0000_00FF);
      rdCheck(5'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
   endtask : resetValues

   task loadBuffer;
      wr(TSA_OFS_PRELOAD, 32'h0000_00F0);
      wr(TSA_OFS_COUNT, 32'h0000_0000);
      rdCheck(TSA_OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_00F0);
      wr(TSA_OFS_PRELOAD, 32'h0000_0010);
      rdCheck(TSA_OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_00F0);
      rdCheck(TSA_OFS_PRELOAD, 32'hFFFF_FFFF, 32'h0000_0010);
      selUse = 4'h2;
      wr(TSA_OFS_PRELOAD, 32'h0000_0055);
      wr(TSA_OFS_COUNT, 32'h0000_0000);
      selUse = 4'h1;
      rdCheck(TSA_OFS_PRELOAD, 32'hFFFF_FFFF, 32'h0000_0010);
      rdCheck(TSA_OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_0010);
   endtask : loadBuffer

   task clockSources;
      wr(TSA_OFS_PRELOAD, 32'h0000_0000);
      for (int s = 1; s <= 3; s++) begin
         wr(TSA_OFS_CTRL, 32'h0000_0004 | s);
         wr(TSA_OFS_COUNT, 32'h0000_0000);
         if (s == 1) begin
            repeat (5) begin
               auxClock <= 1'b1;
               repeat (4) @(posedge clk);
               auxClock <= 1'b0;
               repeat (4) @(posedge clk);
            end
         end else if (s == 2) begin
            peer.pulse(5);
            peer.setLevel(1'b0);
         end else begin
            peer.setLevel(1'b1);
            repeat (9) @(posedge clk);
            peer.setLevel(1'b0);
         end
         repeat (6) @(posedge clk);
         rdCheck(TSA_OFS_COUNT, 32'hFF, s == 3 ? 32'd10 : 32'd5);
      end
      peer.setLevel(1'b1);
      wr(TSA_OFS_PRELOAD, 32'h0000_00FC);
      wr(TSA_OFS_CTRL, 32'h0000_0004);
      wr(TSA_OFS_COUNT, 32'h0000_0000);
      repeat (4) begin
         xfer(1'b0, TSA_OFS_COUNT, TSA_DAT_ZERO);
         check({31'h0, rdq[7:0] >= 8'hFC}, 32'h0000_0001);
      end
   endtask : clockSources

   task fifoFillDrain;
      wr(TSA_OFS_CTRL, 32'h0000_0000);
      for (int i = 0; i < TSA_FIFO_DEPTH; i++) begin
         wr(TSA_OFS_TXBIT, {31'h0, ~i[0]});
      end
      rdCheck(TSA_OFS_STATUS, 32'h0000_0018, 32'h0000_0008);
      wr(TSA_OFS_PRELOAD, 32'h0000_00FF);
      wr(TSA_OFS_COUNT, 32'h0000_0000);
      wr(TSA_OFS_CTRL, 32'h0000_0014);
      repeat (40) @(posedge clk);
      rdCheck(TSA_OFS_STATUS, 32'h0000_0018, 32'h0000_0010);
      check({31'h0, serialOut}, 32'h0000_0000);
      check({31'h0, serialOutEn}, 32'h0000_0001);
   endtask : fifoFillDrain

   task startFrame;
      wr(TSA_OFS_CTRL, 32'h0000_0000);
      wr(TSA_OFS_TXBIT, 32'h0000_0001);
      wr(TSA_OFS_TXBIT, 32'h0000_0000);
      wr(TSA_OFS_PRELOAD, 32'h0000_00C0);
      wr(TSA_OFS_COUNT, 32'h0000_0000);
      wr(TSA_OFS_CTRL, 32'h0000_001C);
      rdCheck(TSA_OFS_STATUS, 32'h0000_0060, 32'h0000_0020);
      rdCheck(TSA_OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_00C0);
      peer.setLevel(1'b0);
      repeat (80) @(posedge clk);
      rdCheck(TSA_OFS_RXBIT, 32'h0000_0001, 32'h0000_0000);
      check({31'h0, serialOut}, 32'h0000_0001);
      rdCheck(TSA_OFS_STATUS, 32'h0000_0062, 32'h0000_0060);
      peer.setLevel(1'b1);
      repeat (45) @(posedge clk);
      rdCheck(TSA_OFS_RXBIT, 32'h0000_0001, 32'h0000_0001);
      check({31'h0, serialOut}, 32'h0000_0000);
   endtask : startFrame

   task summarize;
      $display("Mismatches %0d, comparisons %0d", errCount, checksDone);
      if (errCount == 0 && checksDone > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   initial begin
      #200_000;
      errCount++;
      summarize();
   end

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 5'h00;
      wbSel = 4'h0;
      selUse = 4'h1;
      wbDatW = TSA_DAT_ZERO;
      auxClock = 1'b0;
      errCount = 0;
      checksDone = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      resetValues();
      loadBuffer();
      clockSources();
      fifoFillDrain();
      startFrame();
      summarize();
   end
endmodule : tb_tsa_timer

// ==== tb/tsa_serial_peer.sv ====
`timescale 1ns/1ps
module tsa_serial_peer (
   input  wire logic clk,
   output logic      line
);
   // Idle line sits high until a frame or pulse train starts
   initial line = 1'b1;

   // Level change just after an edge; start bit is a falling edge
   task setLevel(input logic lvl);
      @(posedge clk);
      line <= lvl;
   endtask : setLevel

   // Pulse train for the external count source
   task pulse(input int n);
      for (int i = 0; i < n; i++) begin
         setLevel(1'b0);
         repeat (4) @(posedge clk);
         setLevel(1'b1);
         repeat (4) @(posedge clk);
      end
   endtask : pulse
endmodule : tsa_serial_peer
